/* File: core/neg_status_pkg.sv */
// Package for the negotiation status and rising-edge detect block.
// Assumes a single 250 MHz clock and a plain address/strobe register port.
package neg_status_pkg;

    // ------------------------------------------------------------------
    // Register map (byte offsets on the local register port)
    // ------------------------------------------------------------------
    localparam logic [7:0] NEG_STATUS_ADDR  = 8'h29;
    localparam logic [7:0] EDGE_MASK_ADDR   = 8'h2A;
    localparam logic [7:0] IRQ_ENABLE_ADDR  = 8'h22;
    localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h23;

    localparam logic [7:0] NEG_STATUS_RESET = 8'h00;
    localparam logic [7:0] EDGE_MASK_RESET  = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int NEG_SUCCESS_BIT   = 7;
    localparam int NEG_FAILURE_BIT   = 6;
    localparam int HOST_TIMEOUT_BIT  = 5;
    localparam int ABRUPT_TERM_BIT   = 4;
    localparam int MODE_CHANGE_BIT   = 5;
    localparam int LINE_CHANGE_BIT   = 4;
    localparam int HOST_LINE_COUNT   = 4;
    localparam int SYNC_STAGES       = 2;

    // ------------------------------------------------------------------
    // Result codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        RES_COMPAT_IDLE   = 4'h0,
        RES_FAILED        = 4'h1,
        RES_COMPAT_TERM   = 4'h2,
        RES_EPP           = 4'h6,
        RES_NIBBLE        = 4'h8,
        RES_NIBBLE_ID     = 4'h9,
        RES_BYTE          = 4'hA,
        RES_BYTE_ID       = 4'hB,
        RES_ECP           = 4'hC,
        RES_ECP_ID        = 4'hD,
        RES_ECP_RLE       = 4'hE,
        RES_ECP_RLE_ID    = 4'hF
    } result_code_t;

endpackage

/* File: core/line_sync_rise.sv */
// Two-flop synchroniser with a rising-edge pulse on one host line.
// Assumes the host line is asynchronous to clock.
`timescale 1ns/1ps
module line_sync_rise (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic line_in,
    output logic      rise_pulse
);
    import neg_status_pkg::*;

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // The first stage is read only by the second stage.
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= line_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise_pulse = sync_q & ~prev_q;

endmodule

/* File: core/negotiation_status_edge_detect.sv */
// Negotiation status register, rising-edge detect mask and parallel irq logic.
// Assumes the negotiation engine reports mode changes as one-cycle pulses and
// the register port strobes are single-cycle and never both high at once.
`timescale 1ns/1ps
module negotiation_status_edge_detect #(
    parameter int LINES = neg_status_pkg::HOST_LINE_COUNT
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_write,
    input  wire logic                       reg_read,
    output logic      [7:0]                 reg_rdata,
    input  wire logic                       mode_update,
    input  wire neg_status_pkg::result_code_t mode_code,
    input  wire logic                       outcome_success,
    input  wire logic                       outcome_failure,
    input  wire logic                       outcome_timeout,
    input  wire logic                       outcome_abrupt,
    input  wire logic                       manual_mode,
    input  wire logic                       host_active_line,
    input  wire logic                       host_initialize_line,
    input  wire logic                       host_busy_line,
    input  wire logic                       host_strobe_line,
    output logic      [7:0]                 negotiation_status,
    output logic                            parallel_irq
);
    import neg_status_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic [7:0]       negotiation_status_reg_q;
    logic [LINES-1:0] rising_edge_detect_mask_q;
    logic [7:0]       parallel_irq_enable_reg_q;
    logic [7:0]       parallel_irq_status_reg_q;
    logic [7:0]       rdata_q;
    logic             irq_q;
    logic [LINES-1:0] host_lines;
    logic [LINES-1:0] line_rise;
    logic             code_legal;
    logic             mode_change_irq;
    logic             line_change_irq;
    logic             wr_status;
    logic             wr_mask;
    logic             wr_enable;
    logic             wr_irq_status;
    logic [7:0]       irq_status_d;
    logic [7:0]       rdata_d;

    assign host_lines = {host_active_line, host_initialize_line,
                         host_busy_line, host_strobe_line};

    // ------------------------------------------------------------------
    // Host line synchronisers
    // ------------------------------------------------------------------
    for (genvar i = 0; i < LINES; i++) begin : g_line
        line_sync_rise u_sync (
            .clock      (clock),
            .rst        (rst),
            .line_in    (host_lines[i]),
            .rise_pulse (line_rise[i])
        );
    end

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    assign wr_status     = reg_write && (reg_addr == NEG_STATUS_ADDR);
    assign wr_mask       = reg_write && (reg_addr == EDGE_MASK_ADDR);
    assign wr_enable     = reg_write && (reg_addr == IRQ_ENABLE_ADDR);
    assign wr_irq_status = reg_write && (reg_addr == IRQ_STATUS_ADDR);

    // Reserved codes are screened so a faulty engine input cannot leak them.
    always_comb begin
        case (mode_code)
            4'h3, 4'h4, 4'h5, 4'h7: code_legal = 1'b0;
            default:                code_legal = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------
    // Negotiation status register
    // ------------------------------------------------------------------
    // A mode update in the same cycle as a clearing write wins, so the new
    // mode is never lost; software sees it on its next read.
    always_ff @(posedge clock) begin
        if (rst) begin
            negotiation_status_reg_q <= NEG_STATUS_RESET;
        end else if (mode_update && code_legal) begin
            negotiation_status_reg_q[3:0] <= mode_code;
            negotiation_status_reg_q[NEG_SUCCESS_BIT] <= outcome_success;
            negotiation_status_reg_q[NEG_FAILURE_BIT] <= outcome_failure;
            negotiation_status_reg_q[HOST_TIMEOUT_BIT] <= outcome_timeout;
            negotiation_status_reg_q[ABRUPT_TERM_BIT] <= outcome_abrupt;
        end else if (wr_status) begin
            negotiation_status_reg_q <= NEG_STATUS_RESET;
        end
    end

    // ------------------------------------------------------------------
    // Rising-edge detect mask and interrupt enable
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            rising_edge_detect_mask_q <= EDGE_MASK_RESET[LINES-1:0];
        end else if (wr_mask) begin
            rising_edge_detect_mask_q <= reg_wdata[LINES-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            parallel_irq_enable_reg_q <= IRQ_ENABLE_RESET;
        end else if (wr_enable) begin
            parallel_irq_enable_reg_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt events and status
    // ------------------------------------------------------------------
    assign mode_change_irq = mode_update && code_legal;
    // Leaving Manual mode does not clear a pending flag; only a write or a read of the interrupt status register does.
    assign line_change_irq = manual_mode
                           && |(line_rise & rising_edge_detect_mask_q);

    always_comb begin
        irq_status_d = parallel_irq_status_reg_q;
        if (wr_irq_status || (reg_read && reg_addr == IRQ_STATUS_ADDR)) begin
            irq_status_d = IRQ_STATUS_RESET;
        end
        if (mode_change_irq) begin
            irq_status_d[MODE_CHANGE_BIT] = 1'b1;
        end
        if (line_change_irq) begin
            irq_status_d[LINE_CHANGE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            parallel_irq_status_reg_q <= IRQ_STATUS_RESET;
        end else begin
            parallel_irq_status_reg_q <= irq_status_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_d & parallel_irq_enable_reg_q);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            NEG_STATUS_ADDR: rdata_d = negotiation_status_reg_q;
            EDGE_MASK_ADDR:  rdata_d = {{(8-LINES){1'b0}}, rising_edge_detect_mask_q};
            IRQ_ENABLE_ADDR: rdata_d = parallel_irq_enable_reg_q;
            IRQ_STATUS_ADDR: rdata_d = parallel_irq_status_reg_q;
            default:         rdata_d = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= UNMAPPED_READ;
        end else if (reg_read) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= UNMAPPED_READ;
        end
    end

    assign reg_rdata          = rdata_q;
    assign negotiation_status = negotiation_status_reg_q;
    assign parallel_irq       = irq_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence mode_event_s;
        mode_update && code_legal;
    endsequence

    sequence write_status_s;
        wr_status && !mode_update;
    endsequence

    property code_loaded_p;
        @(posedge clock) disable iff (rst)
        mode_event_s |=> negotiation_status_reg_q[3:0] == $past(mode_code);
    endproperty

    result_code_a: assert property (code_loaded_p)
        else $error("result code not loaded on mode update");

    reserved_never_a: assert property (@(posedge clock) disable iff (rst)
        !(negotiation_status_reg_q[3:0] inside {4'h3, 4'h4, 4'h5, 4'h7}))
        else $error("reserved result code present");

    status_clear_a: assert property (@(posedge clock) disable iff (rst)
        write_status_s |=> negotiation_status_reg_q == NEG_STATUS_RESET)
        else $error("status not cleared by write");

    outcome_bits_a: assert property (@(posedge clock) disable iff (rst)
        mode_event_s |=> negotiation_status_reg_q[7:4] ==
            $past({outcome_success, outcome_failure, outcome_timeout, outcome_abrupt}))
        else $error("outcome bits not loaded");

    mode_irq_a: assert property (@(posedge clock) disable iff (rst)
        (mode_event_s and parallel_irq_enable_reg_q[MODE_CHANGE_BIT]) |=> parallel_irq)
        else $error("mode change did not raise interrupt");

    line_irq_a: assert property (@(posedge clock) disable iff (rst)
        line_change_irq && parallel_irq_enable_reg_q[LINE_CHANGE_BIT] |=> parallel_irq)
        else $error("line change did not raise interrupt");

    manual_only_a: assert property (@(posedge clock) disable iff (rst)
        !manual_mode |-> !line_change_irq)
        else $error("line change flagged outside manual mode");

    mask_upper_a: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == EDGE_MASK_ADDR |=> reg_rdata[7:4] == 4'h0)
        else $error("mask upper bits not zero");

    irq_withdraw_a: assert property (@(posedge clock) disable iff (rst)
        wr_irq_status && !mode_update && !line_change_irq |=> !parallel_irq)
        else $error("interrupt not withdrawn by status write");

    // ------------------------------------------------------------------
    // Per-line edge checks
    // ------------------------------------------------------------------
    // A line held high for many cycles must flag once, and only after it
    // has passed both synchroniser stages.
    for (genvar j = 0; j < LINES; j++) begin : g_rise_chk
        single_rise_a: assert property (@(posedge clock) disable iff (rst)
            line_rise[j] |=> !line_rise[j])
            else $error("rising edge flagged twice");

        rise_source_a: assert property (@(posedge clock) disable iff (rst)
            line_rise[j] |-> $past(host_lines[j], 2))
            else $error("edge flagged without a high host line");
    end

    // ------------------------------------------------------------------
    // Register side effects and interrupt level
    // ------------------------------------------------------------------
    // These cover what the load and clear checks above cannot see: codes
    // that must be dropped, read-back paths and the level of the output.
    sequence reserved_event_s;
        mode_update && !code_legal && !wr_status;
    endsequence

    sequence quiet_status_s;
        !mode_update && !wr_status;
    endsequence

    sequence irq_read_s;
        reg_read && reg_addr == IRQ_STATUS_ADDR && !mode_change_irq && !line_change_irq;
    endsequence

    reserved_drop_a: assert property (@(posedge clock) disable iff (rst)
        reserved_event_s |=> $stable(negotiation_status_reg_q))
        else $error("reserved code changed the status register");

    status_hold_a: assert property (@(posedge clock) disable iff (rst)
        quiet_status_s |=> $stable(negotiation_status_reg_q))
        else $error("status changed without a mode update");

    compat_term_a: assert property (@(posedge clock) disable iff (rst)
        (mode_event_s and mode_code == RES_COMPAT_TERM) |=>
            negotiation_status_reg_q[3:0] == RES_COMPAT_TERM)
        else $error("termination code not loaded");

    status_readback_a: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == NEG_STATUS_ADDR |=> reg_rdata == $past(negotiation_status_reg_q))
        else $error("status read data differs from register");

    mask_store_a: assert property (@(posedge clock) disable iff (rst)
        wr_mask |=> rising_edge_detect_mask_q == $past(reg_wdata[LINES-1:0]))
        else $error("edge detect mask not stored");

    mask_readback_a: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == EDGE_MASK_ADDR |=>
            reg_rdata[LINES-1:0] == $past(rising_edge_detect_mask_q))
        else $error("mask read data differs from register");

    mode_flag_a: assert property (@(posedge clock) disable iff (rst)
        mode_event_s |=> parallel_irq_status_reg_q[MODE_CHANGE_BIT])
        else $error("mode change flag not set");

    line_flag_a: assert property (@(posedge clock) disable iff (rst)
        line_change_irq |=> parallel_irq_status_reg_q[LINE_CHANGE_BIT])
        else $error("line change flag not set");

    mask_quiet_a: assert property (@(posedge clock) disable iff (rst)
        rising_edge_detect_mask_q == '0 |-> !line_change_irq)
        else $error("line change flagged with an empty mask");

    irq_read_clear_a: assert property (@(posedge clock) disable iff (rst)
        irq_read_s |=> parallel_irq_status_reg_q == IRQ_STATUS_RESET)
        else $error("interrupt status not cleared by read");

    irq_level_a: assert property (@(posedge clock) disable iff (rst)
        !wr_enable |=> parallel_irq ==
            |(parallel_irq_status_reg_q & parallel_irq_enable_reg_q))
        else $error("interrupt level differs from enabled status");

endmodule

/* File: sim/host_line_model.sv */
// Host side of the cable: drives the four monitored control lines.
// Assumes the bench requests a rise with a one-cycle pulse on launch.
`timescale 1ns/1ps
module host_line_model (
    input  wire logic [3:0] launch,
    output wire logic [3:0] host_lines
);
    // ------------------------------------------------------------------
    // Line timing
    // ------------------------------------------------------------------
    // The rise lands off the clock edge, as a real cable would, and the
    // line is held long enough to prove that one rise flags only once.
    for (genvar i = 0; i < 4; i++) begin : g_line
        logic line_v = 1'b0;

        always @(posedge launch[i]) begin
            #1.7 line_v = 1'b1;
            #40 line_v = 1'b0;
        end

        assign host_lines[i] = line_v;
    end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the negotiation status and edge detect block.
// Assumes the design package is compiled first and the host model beside it.
`timescale 1ns/1ps
module testbench;
    import neg_status_pkg::*;

    logic         clock, rst, reg_write, reg_read, mode_update, manual_mode;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata, negotiation_status, exp_st;
    logic [3:0]   launch, host_lines, outs;
    result_code_t mode_code;
    logic         parallel_irq;
    logic         rd_seen = 1'b0;
    logic [7:0]   exp_q[$];
    int           n_mismatch = 0;
    int           check_count = 0;

    host_line_model host (.launch(launch), .host_lines(host_lines));

    negotiation_status_edge_detect uut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .mode_update(mode_update), .mode_code(mode_code),
        .outcome_success(outs[3]), .outcome_failure(outs[2]),
        .outcome_timeout(outs[1]), .outcome_abrupt(outs[0]),
        .manual_mode(manual_mode), .host_active_line(host_lines[3]),
        .host_initialize_line(host_lines[2]), .host_busy_line(host_lines[1]),
        .host_strobe_line(host_lines[0]), .negotiation_status(negotiation_status),
        .parallel_irq(parallel_irq));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(exp);
        @(posedge clock);
        reg_read <= 1'b0;
    endtask

    task automatic pulse(input logic [3:0] c, input logic [3:0] o);
        @(posedge clock);
        mode_update <= 1'b1;
        mode_code   <= result_code_t'(c);
        outs        <= o;
        @(posedge clock);
        mode_update <= 1'b0;
        #1;
    endtask

    task automatic fire(input logic [3:0] m);
        @(posedge clock);
        launch <= m;
        @(posedge clock);
        launch <= 4'h0;
    endtask

    // A bounded watch: did the interrupt show at all within n cycles.
    task automatic irq_within(input logic exp, input int n);
        logic hit;
        logic bad;
        hit = 1'b0;
        bad = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            #1;
            if (parallel_irq === 1'b1) hit = 1'b1;
            if (parallel_irq !== 1'b0 && parallel_irq !== 1'b1) bad = 1'b1;
        end
        check({6'h00, bad, hit}, {7'h00, exp}, "interrupt");
    endtask

    // ------------------------------------------------------------------
    // Read data monitor
    // ------------------------------------------------------------------
    // Read data is valid in the one cycle after the strobe and 00 otherwise.
    always @(posedge clock) begin
        if (rd_seen)
            check(reg_rdata, exp_q.pop_front(), "read data");
        else if (!rst)
            check(reg_rdata, 8'h00, "idle read data");
        rd_seen <= reg_read;
    end

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        #100000;
        n_mismatch++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        complete_run();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {reg_write, reg_read, mode_update, manual_mode} = 4'h0;
        {reg_addr, reg_wdata, launch, outs} = 24'h000000;
        mode_code = RES_COMPAT_IDLE;
        rst = 1'b1;
        void'($urandom(32'h3bb9));
        repeat (3) @(posedge clock);
        rst <= 1'b0;

        rd(NEG_STATUS_ADDR, 8'h00);
        rd(EDGE_MASK_ADDR, 8'h00);
        rd(IRQ_ENABLE_ADDR, 8'h00);
        rd(IRQ_STATUS_ADDR, 8'h00);
        rd(8'h10, 8'h00);
        $display("test reset values done");

        exp_st = 8'h00;
        for (int c = 0; c < 16; c++) begin
            pulse(4'(c), 4'($urandom()));
            if (!(c inside {3, 4, 5, 7})) exp_st = {outs, 4'(c)};
            check(negotiation_status, exp_st, "status after mode update");
            rd(NEG_STATUS_ADDR, exp_st);
        end
        wr(NEG_STATUS_ADDR, 8'($urandom()));
        #1;
        check(negotiation_status, 8'h00, "status after clearing write");
        rd(NEG_STATUS_ADDR, 8'h00);
        $display("test result codes done");

        wr(IRQ_STATUS_ADDR, 8'($urandom()));
        wr(IRQ_ENABLE_ADDR, 8'h20);
        pulse(4'h6, 4'h8);
        irq_within(1'b1, 3);
        rd(IRQ_STATUS_ADDR, 8'h20);
        irq_within(1'b0, 3);
        pulse(4'hC, 4'h8);
        irq_within(1'b1, 3);
        wr(IRQ_STATUS_ADDR, 8'($urandom()));
        irq_within(1'b0, 3);
        wr(IRQ_ENABLE_ADDR, 8'h00);
        pulse(4'h2, 4'h1);
        irq_within(1'b0, 4);
        rd(IRQ_STATUS_ADDR, 8'h20);
        $display("test mode change interrupt done");

        wr(EDGE_MASK_ADDR, 8'hFF);
        rd(EDGE_MASK_ADDR, 8'h0F);
        wr(IRQ_ENABLE_ADDR, 8'h10);
        fire(4'hF);
        irq_within(1'b0, 12);
        rd(IRQ_STATUS_ADDR, 8'h00);
        manual_mode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(EDGE_MASK_ADDR, 8'h01 << i);
            fire(~(4'h1 << i));
            irq_within(1'b0, 12);
            fire(4'h1 << i);
            irq_within(1'b1, 8);
            rd(IRQ_STATUS_ADDR, 8'h10);
            irq_within(1'b0, 8);
        end
        $display("test edge detect done");

        repeat (4) @(posedge clock);
        complete_run();
    end
endmodule
